/* hdl/sbas_defines.vh */
`ifndef SBAS_DEFINES_VH
`define SBAS_DEFINES_VH

`define SBAS_SLAVE_ADDR  7'h34
`define SBAS_CMD_BLK_WR  8'hFC
`define SBAS_CMD_BLK_RD  8'hFD
`define SBAS_RAM_TOP     8'hDF
`define SBAS_EE_HI_FIRST 8'hF8
`define SBAS_EE_HI_LAST  8'hFB
`define SBAS_RAM_HI      8'h00
`define SBAS_RD_COUNT    8'h20
`define SBAS_BLK_MAX     6'h20
`define SBAS_IDX_MAX     6'h3F
`define SBAS_IDX_LAST_RD 6'h20
`define SBAS_CRC_POLY    8'h07
`define SBAS_CRC_INIT    8'h00
`define SBAS_BIT_LAST    4'h7
`define SBAS_BIT_ACK     4'h8
`define SBAS_PROG_US     250
`define SBAS_CLK_KHZ     50000

`endif

/* hdl/sbas_crc8.v */
`timescale 1ns/1ns
`include "sbas_defines.vh"

module sbas_crc8 (
  input  wire [7:0] crc_in,
  input  wire [7:0] data,
  output reg  [7:0] crc_out
);

  integer i;

  // bitwise CRC-8 over one byte, msb first
  always @* begin
    crc_out = crc_in ^ data;
    for (i = 0; i < 8; i = i + 1) begin
      if (crc_out[7]) begin
        crc_out = {crc_out[6:0], 1'b0} ^ `SBAS_CRC_POLY;
      end else begin
        crc_out = {crc_out[6:0], 1'b0};
      end
    end
  end

endmodule // sbas_crc8

/* hdl/sbas_slave.v */
`timescale 1ns/1ns
`include "sbas_defines.vh"

module sbas_slave #(
  parameter [6:0]   SLAVE_ADDR = `SBAS_SLAVE_ADDR,
  parameter integer PROG_CYC   = (`SBAS_PROG_US * `SBAS_CLK_KHZ) / 1000
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         scl_out,
  output reg         scl_oe,
  output reg         sda_out,
  output reg         sda_oe,
  output reg  [15:0] mem_addr,
  output reg  [7:0]  mem_wdata,
  output reg         mem_wr,
  input  wire [7:0]  mem_rdata,
  input  wire        erase_busy
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_RX   = 3'h2;
  localparam [2:0] S_TX   = 3'h3;

  localparam [15:0] PROG_LOAD = PROG_CYC[15:0];

  // pin synchronisers and edge history
  reg        scl_m;
  reg        scl_s;
  reg        scl_d;
  reg        sda_m;
  reg        sda_s;
  reg        sda_d;

  // protocol state
  reg [2:0]  state;
  reg [3:0]  bitn;
  reg [7:0]  sh;
  reg [5:0]  idx;
  reg [7:0]  cmd;
  reg [7:0]  ee_hi;
  reg [5:0]  blk_left;
  reg        rd_arm;
  reg        in_xfer;
  reg        ack_go;
  reg [7:0]  crc;

  // write path and programming timer
  reg        pend_wr;
  reg        pend_inc;
  reg        inc_now;
  reg [15:0] prog_cnt;

  reg [7:0]  next_tx;

  wire       scl_rise;
  wire       scl_fall;
  wire       start_c;
  wire       stop_c;
  wire [7:0] byte_in;
  wire [7:0] crc_nx;
  wire       cmd_is_ram;
  wire       cmd_is_ee;
  wire       addr_is_ee;

  // bus conditions seen from the synchronised pins
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;
  assign byte_in  = {sh[6:0], sda_s};

  // decode of the stored command byte and of the pointer
  assign cmd_is_ram = (cmd <= `SBAS_RAM_TOP);
  assign cmd_is_ee  = (cmd >= `SBAS_EE_HI_FIRST) && (cmd <= `SBAS_EE_HI_LAST);
  assign addr_is_ee = (mem_addr[15:8] >= `SBAS_EE_HI_FIRST);

  sbas_crc8 u_crc (
    .crc_in  (crc),
    .data    (byte_in),
    .crc_out (crc_nx)
  );

  // byte to put on the bus at the next transmit slot
  always @* begin
    if (!rd_arm) begin
      next_tx = (idx == 6'h00) ? mem_rdata : crc;
    end else if (idx == 6'h00) begin
      next_tx = `SBAS_RD_COUNT;
    end else if (idx <= `SBAS_IDX_LAST_RD) begin
      next_tx = mem_rdata;
    end else begin
      next_tx = crc;
    end
  end

  // two flip-flops on each pin before any logic looks at it
  always @(posedge clk) begin
    if (!reset_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // protocol engine, pin drivers, memory writes and programming timer
  always @(posedge clk) begin
    if (!reset_n) begin
      scl_out   <= 1'b0;
      scl_oe    <= 1'b0;
      sda_out   <= 1'b0;
      sda_oe    <= 1'b0;
      mem_addr  <= 16'h0000;
      mem_wdata <= 8'h00;
      mem_wr    <= 1'b0;
      state     <= S_IDLE;
      bitn      <= 4'h0;
      sh        <= 8'h00;
      idx       <= 6'h00;
      cmd       <= 8'h00;
      ee_hi     <= 8'h00;
      blk_left  <= 6'h00;
      rd_arm    <= 1'b0;
      in_xfer   <= 1'b0;
      ack_go    <= 1'b0;
      crc       <= `SBAS_CRC_INIT;
      pend_wr   <= 1'b0;
      pend_inc  <= 1'b0;
      inc_now   <= 1'b0;
      prog_cnt  <= 16'h0000;
    end else begin
      mem_wr  <= 1'b0;
      inc_now <= 1'b0;
      if (start_c) begin
        // start or repeated start: the CRC survives a repeated start
        state  <= S_ADDR;
        bitn   <= 4'h0;
        sda_oe <= 1'b0;
        in_xfer <= 1'b1;
        if (!in_xfer) begin
          crc <= `SBAS_CRC_INIT;
        end
      end else if (stop_c) begin
        state   <= S_IDLE;
        sda_oe  <= 1'b0;
        in_xfer <= 1'b0;
        rd_arm  <= 1'b0;
      end else if (state != S_IDLE) begin
        if (scl_rise) begin
          bitn <= (bitn == `SBAS_BIT_ACK) ? 4'h0 : bitn + 4'h1;
          if (bitn != `SBAS_BIT_ACK) begin
            sh <= byte_in;
          end
          if (bitn == `SBAS_BIT_LAST) begin
            crc <= crc_nx;
            case (state)
              S_ADDR: begin
                if ((byte_in[7:1] == SLAVE_ADDR) && !erase_busy) begin
                  ack_go <= 1'b1;
                  state  <= byte_in[0] ? S_TX : S_RX;
                  idx    <= 6'h00;
                end else begin
                  ack_go <= 1'b0;
                end
              end
              S_RX: begin
                ack_go <= 1'b1;
                if (idx != `SBAS_IDX_MAX) begin
                  idx <= idx + 6'h01;
                end
                if (idx == 6'h00) begin
                  cmd    <= byte_in;
                  rd_arm <= (byte_in == `SBAS_CMD_BLK_RD);
                  if (byte_in <= `SBAS_RAM_TOP) begin
                    mem_addr <= {`SBAS_RAM_HI, byte_in};
                  end
                  if ((byte_in >= `SBAS_EE_HI_FIRST) && (byte_in <= `SBAS_EE_HI_LAST)) begin
                    ee_hi <= byte_in;
                  end
                end else if ((cmd == `SBAS_CMD_BLK_WR) && (idx == 6'h01)) begin
                  // byte count, clamped to the block limit
                  blk_left <= (byte_in > {2'b00, `SBAS_BLK_MAX}) ? `SBAS_BLK_MAX
                                                                 : byte_in[5:0];
                end else if ((cmd == `SBAS_CMD_BLK_WR) && (blk_left != 6'h00)) begin
                  blk_left  <= blk_left - 6'h01;
                  pend_wr   <= 1'b1;
                  pend_inc  <= 1'b1;
                  mem_wdata <= byte_in;
                end else if (cmd_is_ee && (idx == 6'h01)) begin
                  mem_addr <= {ee_hi, byte_in};
                end else if ((cmd_is_ee && (idx == 6'h02)) || (cmd_is_ram && (idx == 6'h01))) begin
                  pend_wr   <= 1'b1;
                  pend_inc  <= 1'b0;
                  mem_wdata <= byte_in;
                end else begin
                  ack_go <= (byte_in == crc);
                end
              end
              default: begin
                ack_go <= 1'b0;
              end
            endcase
          end
          // ninth bit: leave on our own NACK or on the master's NACK
          if (bitn == `SBAS_BIT_ACK) begin
            if ((state == S_TX) ? sda_s : !ack_go) begin
              state <= S_IDLE;
            end
          end
        end
        if (scl_fall) begin
          if (bitn == `SBAS_BIT_ACK) begin
            sda_oe <= ack_go;
            if (pend_wr) begin
              scl_oe <= 1'b1;
            end
          end else if ((bitn == 4'h0) && (state == S_TX)) begin
            sh     <= next_tx;
            sda_oe <= ~next_tx[7];
            if (idx != `SBAS_IDX_MAX) begin
              idx <= idx + 6'h01;
            end
            if (rd_arm && (idx != 6'h00) && (idx <= `SBAS_IDX_LAST_RD)) begin
              mem_addr <= mem_addr + 16'h0001;
            end
          end else if (state == S_TX) begin
            sda_oe <= ~sh[7];
          end else begin
            sda_oe <= 1'b0;
          end
        end
      end
      // a pending byte is written only once the previous one has programmed
      if (pend_wr && (prog_cnt == 16'h0000)) begin
        mem_wr   <= 1'b1;
        pend_wr  <= 1'b0;
        scl_oe   <= 1'b0;
        inc_now  <= pend_inc;
        prog_cnt <= addr_is_ee ? PROG_LOAD : 16'h0000;
      end else if (prog_cnt != 16'h0000) begin
        prog_cnt <= prog_cnt - 16'h0001;
      end
      if (inc_now) begin
        mem_addr <= mem_addr + 16'h0001;
      end
    end
  end

endmodule // sbas_slave

/* sim/sbas_chk_checker.sv */
`timescale 1ns/1ns
module sbas_chk #(
  parameter integer PROG_CYC = 20
) (
  input wire        clk,
  input wire        reset_n,
  input wire        scl_in,
  input wire        scl_out,
  input wire        scl_oe,
  input wire        sda_out,
  input wire        sda_oe,
  input wire [15:0] mem_addr,
  input wire        mem_wr,
  input wire        erase_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  integer gap;
  integer hold;
  reg     ee_prev;
  // spacing since the last write and length of the current stretch
  always @(posedge clk) begin
    gap     <= (!reset_n || mem_wr) ? 0 : gap + 1;
    hold    <= (!reset_n || !scl_oe) ? 0 : hold + 1;
    ee_prev <= !reset_n ? 1'b0 : (mem_wr ? mem_addr[15:11] == 5'h1F : ee_prev);
  end
  chk_drive_zero: assert property (!scl_out && !sda_out) else $error("drive value not zero");
  chk_sda_in_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved in high");
  chk_stretch_low: assert property ($rose(scl_oe) |-> !$past(scl_in)) else $error("stretch in high");
  chk_stretch_len: assert property (hold <= PROG_CYC + 2) else $error("stretch too long");
  chk_ee_spacing: assert property (mem_wr && ee_prev && mem_addr[15:11] == 5'h1F
    |-> gap >= PROG_CYC) else $error("eeprom write too soon");
  chk_wr_range: assert property (mem_wr |-> mem_addr <= 16'h00DF
    || (mem_addr >= 16'hF800 && mem_addr <= 16'hFBFF)) else $error("write off map");
  chk_wr_in_ack: assert property (mem_wr |-> !scl_oe && (!$past(scl_oe) || sda_oe)) else $error("write off ack");
  chk_ptr_step: assert property (mem_wr |=> !mem_wr && mem_addr == $past(mem_addr) + 16'h0001)
    else $error("pointer step wrong");
  chk_busy_nack: assert property (erase_busy && $past(erase_busy, 200) |-> !sda_oe)
    else $error("ack while erasing");
  chk_reset_idle: assert property ($rose(reset_n) |-> !scl_oe && !sda_oe && !mem_wr
    && mem_addr == 16'h0000) else $error("reset state wrong");
  cover property (mem_wr && mem_addr[15:11] == 5'h1F);
  cover property (hold == 40);
  cover property ($rose(sda_oe) && erase_busy);
endmodule // sbas_chk
bind sbas_slave sbas_chk #(.PROG_CYC(PROG_CYC)) u_chk (.clk(clk), .reset_n(reset_n),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
  .mem_addr(mem_addr), .mem_wr(mem_wr), .erase_busy(erase_busy));

/* sim/sbas_host.sv */
`timescale 1ns/1ns
module sbas_host (
  input  wire clk,
  input  wire scl_w,
  input  wire sda_w,
  output reg  m_scl,
  output reg  m_sda
);
  initial begin
    m_scl = 1'b1;
    m_sda = 1'b1;
  end
  // one bit: data set in the low phase, sampled late in the high phase
  task bitx(input b, output r);
    begin
      #20 m_sda = b;
      #80 m_scl = 1'b1;
      #1;
      // let the wire settle before asking whether the device stretches
      if (!scl_w) begin
        wait (scl_w);
        @(negedge clk);
        #1;
      end
      #39 r = sda_w;
      #20 m_scl = 1'b0;
    end
  endtask
  // start, also used as repeated start
  task start;
    begin
      #40 m_sda = 1'b1;
      #40 m_scl = 1'b1;
      #40 m_sda = 1'b0;
      #40 m_scl = 1'b0;
    end
  endtask
  task stop;
    begin
      #40 m_sda = 1'b0;
      #40 m_scl = 1'b1;
      #40 m_sda = 1'b1;
      #80;
    end
  endtask
  task wbyte(input [7:0] d, output ack);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1) bitx(d[i], r);
      bitx(1'b1, r);
      ack = !r;
    end
  endtask
  // receive msb first, then ack or nack
  task rbyte(input ack, output [7:0] d);
    integer i;
    reg     r;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        bitx(1'b1, r);
        d = {d[6:0], r};
      end
      bitx(!ack, r);
    end
  endtask
endmodule // sbas_host

/* sim/test_sbas_slave.sv */
`timescale 1ns/1ns
module test_sbas_slave;
  reg         clk, reset_n, erase_busy, ack, stretch_seen;
  reg  [7:0]  b, crc;
  reg  [7:0]  mem [0:65535];
  integer     bad_count, n_tests, i;
  wire        scl_out, scl_oe, sda_out, sda_oe, mem_wr, m_scl, m_sda;
  wire [15:0] mem_addr;
  wire [7:0]  mem_wdata;
  wire        scl_w = m_scl & !scl_oe;
  wire        sda_w = m_sda & !sda_oe;
  sbas_slave #(.SLAVE_ADDR(7'h34), .PROG_CYC(200)) dut_u (.clk(clk), .reset_n(reset_n),
    .scl_in(scl_w), .sda_in(sda_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
    .sda_oe(sda_oe), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
    .mem_rdata(mem[mem_addr]), .erase_busy(erase_busy));
  sbas_host h (.clk(clk), .scl_w(scl_w), .sda_w(sda_w), .m_scl(m_scl), .m_sda(m_sda));
  // memory behind the pointer
  always @(posedge clk) if (mem_wr) mem[mem_addr] <= mem_wdata;
  // remembers whether the device ever held the clock low
  always @(posedge clk) stretch_seen <= reset_n & (stretch_seen | scl_oe);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
    end
  endtask
  function [7:0] crc8(input [7:0] c, input [7:0] d);
    integer k;
    begin
      crc8 = c ^ d;
      for (k = 0; k < 8; k = k + 1) crc8 = {crc8[6:0], 1'b0} ^ (crc8[7] ? 8'h07 : 8'h00);
    end
  endfunction
  // bytes to and from the device, with running check value
  task wr(input [7:0] d, input a);
    begin
      h.wbyte(d, ack);
      crc = crc8(crc, d);
      check({7'h00, ack}, {7'h00, a});
    end
  endtask
  task rd(input a, input [7:0] e);
    begin
      h.rbyte(a, b);
      crc = crc8(crc, e);
      check(b, e);
    end
  endtask
  task open_wr(input [7:0] c);
    begin
      crc = 8'h00;
      h.start;
      wr(8'h68, 1'b1);
      wr(c, 1'b1);
    end
  endtask
  task t_blk_wr;
    begin
      open_wr(8'h10);
      h.stop;
      open_wr(8'hFC);
      wr(8'h03, 1'b1);
      for (i = 0; i < 3; i = i + 1) wr(8'hA0 + i, 1'b1);
      wr(crc, 1'b1);
      h.stop;
      for (i = 0; i < 3; i = i + 1) check(mem[16'h10 + i], 8'hA0 + i);
      open_wr(8'hF9);
      // two bytes from 0xF9FE stay below the top and inside one erased page
      wr(8'hFE, 1'b1);
      h.stop;
      open_wr(8'hFC);
      for (i = 0; i < 3; i = i + 1) wr(8'h02 + 8'h4F * i, 1'b1);
      h.stop;
      check(mem[16'hF9FE], 8'h51);
      check(mem[16'hF9FF], 8'hA0);
      check({7'h00, stretch_seen}, 8'h01);
    end
  endtask
  task t_blk_rd;
    begin
      open_wr(8'hC0);
      h.stop;
      open_wr(8'hFD);
      h.start;
      wr(8'h69, 1'b1);
      rd(1'b1, 8'h20);
      for (i = 0; i < 32; i = i + 1) rd(1'b1, mem[16'hC0 + i]);
      h.rbyte(1'b0, b);
      check(b, crc);
      h.stop;
    end
  endtask
  task t_rx_refuse;
    begin
      open_wr(8'h20);
      h.stop;
      repeat (2) begin
        h.start;
        wr(8'h69, 1'b1);
        rd(1'b0, mem[16'h0020]);
        h.stop;
      end
      @(negedge clk) erase_busy = 1'b1;
      repeat (200) @(negedge clk);
      h.start;
      wr(8'h68, 1'b0);
      h.stop;
      erase_busy = 1'b0;
      h.start;
      wr(8'h6A, 1'b0);
      h.stop;
    end
  endtask
  task final_report;
    begin
      if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    reset_n = 1'b0;
    erase_busy = 1'b0;
    bad_count = 0;
    n_tests = 0;
    crc = 8'h00;
    for (i = 0; i < 65536; i = i + 1) mem[i] = i ^ 8'h5A;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    t_blk_wr;
    t_blk_rd;
    t_rx_refuse;
    final_report;
  end
  // watchdog: the scenarios need about 5200 cycles, allow 20000
  initial begin
    #400000;
    bad_count = bad_count + 1;
    final_report;
  end
endmodule // test_sbas_slave
